//--- verilog/mdmux_top.sv
// multidrop scan port mux: addressing, local port routing and pass-through
// Summary of operation
// - tristate notify goes high whenever its test data output floats
// - master pass-through inputs reach the single selected local port only
// - master pass-through outputs show the single selected port's inputs
// - local pass-through inputs exist on ports zero and one only
// - local pass-through outputs on ports zero and one, single selection only
// - local output enable high floats every local port output
// - local test clocks are copies of the master port clock, resampled on the system clock
// - local test resets are gated from the backplane test reset
// - low backplane test reset asynchronously initializes internal logic
// - master port select picks master; the other port is local port zero
// - system clock runs all scan logic; backplane test clock edges are sampled on it
// - backplane address is the static level of eight slot inputs
// - level one selects one device, a group, or all via broadcast
// - level two picks any of seven local ports into one chain
// - select zero makes port zero master, one makes port one master
// - idle local resets follow level input; driven low while reset active
`timescale 1ns/10ps
`default_nettype none
module mdmux_top
  import mdmux_pkg::*;
(
  input  wire logic [1:0]         TCK_B_IN,
  input  wire logic               SYS_CLK_IN,
  input  wire logic               RST_N_IN,
  output var  logic [1:0]         TCK_B_OUT,
  output var  logic [1:0]         TCK_B_OE_N_OUT,
  input  wire logic [1:0]         TMS_B_IN,
  output var  logic [1:0]         TMS_B_OUT,
  output var  logic [1:0]         TMS_B_OE_N_OUT,
  input  wire logic [1:0]         TRST_B_N_IN,
  output var  logic [1:0]         TRST_B_N_OUT,
  output var  logic [1:0]         TRST_B_OE_N_OUT,
  input  wire logic [1:0]         TDI_B_IN,
  output var  logic [1:0]         TDO_B_OUT,
  output var  logic [1:0]         TDO_B_OE_N_OUT,
  input  wire logic [3:0]         PT_B_IN,
  output var  logic [3:0]         PT_B_OUT,
  output var  logic [1:0]         PT_B_OE_N_OUT,
  output var  logic [4:0]         TRISTATE_NOTIFY_OUT,
  output var  logic [5:0]         TCK_L_OUT,
  output var  logic [5:0]         TMS_L_OUT,
  output var  logic [5:0]         TRST_L_N_OUT,
  output var  logic [5:0]         TDO_L_OUT,
  output var  logic [5:0]         TDO_L_OE_N_OUT,
  output var  logic               LOC_OE_N_OUT,
  input  wire logic [5:0]         TDI_L_IN,
  input  wire logic [1:0]         PT_L_IN,
  output var  logic [1:0]         PT_L_OUT,
  output var  logic               PT_L_OE_N_OUT,
  input  wire logic [7:0]         SLOT_ID_IN,
  input  wire logic [1:0]         GROUP_ID_IN,
  input  wire logic               MASTER_PORT_SELECT_IN,
  input  wire logic               LOCAL_OE_N_IN,
  input  wire logic               IDLE_LOCAL_RESET_LEVEL_IN,
  input  wire logic               BACKPLANE_RESET_MASK_IN,
  output var  logic               DEVICE_SELECTED_OUT,
  output var  logic [6:0]         PORT_SELECT_OUT
);
  import mdmux_pkg::*;

  if (N_LOCAL != 7 || SLOT_W != 8 || IR_W < SLOT_W) begin : g_bad_cfg
    $error("mdmux_top: unsupported port count or widths");
  end

  // sync stages reset to pin idle levels: no false enable, reset or edge
  localparam pins_t PINS_IDLE = '{tck: 2'h0, tms: 2'h3, tdi: 2'h3, trst_n: 2'h3, pt_b: '0,
                                  pt_l: '0, tdi_l: '1, slot: '0, group: '0, mps: 1'b0,
                                  loc_oe_n: 1'b1, idle_rst: 1'b0, rst_mask: 1'b0};

  function automatic logic pick(input logic [1:0] v, input logic sel);
    return sel ? v[1] : v[0];
  endfunction

  function automatic logic one_hot(input logic [N_LOCAL-1:0] v);
    return (v != '0) && ((v & (v - 1'b1)) == '0);
  endfunction

  pins_t              pins_raw;
  pins_t              sync1_q;
  pins_t              sync2_q;
  logic               core_rst_n;
  logic               m;
  logic               tck_m;
  logic               tms_m;
  logic               tdi_m;
  logic               tck_prev_q;
  logic               tck_rise;
  logic               tck_fall;
  tap_state_t         tap_state;
  logic [IR_W-1:0]    ir_sh_q;
  logic [IR_W-1:0]    ir_q;
  logic               selected_q;
  logic [N_LOCAL-1:0] port_sel_q;
  logic [N_LOCAL-1:0] dr_sh_q;
  logic               bypass_q;
  logic               tdo_q;
  logic               tdo_en_q;
  logic [N_LOCAL-1:0] live;
  logic               single;
  logic [N_LOCAL-1:0] loc_tdi;
  logic [N_LOCAL-1:0] loc_tdo_d;
  logic               chain_out;
  logic [IR_W-1:0]    group_addr;
  logic               addr_hit;
  logic               trst_l0_d;

  assign pins_raw = '{tck: TCK_B_IN, tms: TMS_B_IN, tdi: TDI_B_IN, trst_n: TRST_B_N_IN,
                      pt_b: PT_B_IN, pt_l: PT_L_IN, tdi_l: TDI_L_IN, slot: SLOT_ID_IN,
                      group: GROUP_ID_IN, mps: MASTER_PORT_SELECT_IN,
                      loc_oe_n: LOCAL_OE_N_IN, idle_rst: IDLE_LOCAL_RESET_LEVEL_IN,
                      rst_mask: BACKPLANE_RESET_MASK_IN};

  // select is a strap, so the raw mux only moves at board config time
  assign core_rst_n = RST_N_IN & pick(TRST_B_N_IN, MASTER_PORT_SELECT_IN);

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sync1_q <= PINS_IDLE;
      sync2_q <= PINS_IDLE;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  assign m     = sync2_q.mps;
  assign tck_m = pick(sync2_q.tck, m);
  assign tms_m = pick(sync2_q.tms, m);
  assign tdi_m = pick(sync2_q.tdi, m);

  // tck edges found by sampling; tck must stay well below sys clock / 4
  always_ff @(posedge SYS_CLK_IN or negedge core_rst_n) begin
    if (!core_rst_n) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_m;
    end
  end
  assign tck_rise = tck_m & ~tck_prev_q;
  assign tck_fall = ~tck_m & tck_prev_q;

  tap_fsm u_tap (
    .clk_in      (SYS_CLK_IN),
    .rst_n_in    (core_rst_n),
    .tck_rise_in (tck_rise),
    .tms_in      (tms_m),
    .state_out   (tap_state)
  );

  assign group_addr = GROUP_ADDR_BASE + IR_W'(sync2_q.group);
  assign addr_hit   = (ir_sh_q == sync2_q.slot) || (ir_sh_q == BCAST_ADDR) ||
                      (ir_sh_q == group_addr);

  // instruction path and level one addressing
  always_ff @(posedge SYS_CLK_IN or negedge core_rst_n) begin
    if (!core_rst_n) begin
      ir_sh_q    <= IR_RESET_VAL;
      ir_q       <= IR_RESET_VAL;
      selected_q <= 1'b0;
    end else if (tck_rise) begin
      unique case (tap_state)
        TAP_CAP_IR:   ir_sh_q <= IR_CAPTURE_VAL;
        TAP_SHIFT_IR: ir_sh_q <= {tdi_m, ir_sh_q[IR_W-1:1]};
        TAP_UPD_IR: begin
          if (!selected_q) begin
            selected_q <= addr_hit;
          end else if (ir_sh_q == RELEASE_INSTR) begin
            selected_q <= 1'b0;
          end
          ir_q <= ir_sh_q;
        end
        TAP_RESET:    ir_q <= IR_RESET_VAL;
        default:      ir_q <= ir_q;
      endcase
    end
  end

  // level two port selection register
  always_ff @(posedge SYS_CLK_IN or negedge core_rst_n) begin
    if (!core_rst_n) begin
      dr_sh_q    <= PORT_SEL_RESET;
      port_sel_q <= PORT_SEL_RESET;
      bypass_q   <= 1'b0;
    end else if (tck_rise && ir_q == PORT_SEL_INSTR && selected_q) begin
      unique case (tap_state)
        TAP_CAP_DR:   dr_sh_q <= port_sel_q;
        TAP_SHIFT_DR: dr_sh_q <= {tdi_m, dr_sh_q[N_LOCAL-1:1]};
        TAP_UPD_DR:   port_sel_q <= dr_sh_q;
        default:      dr_sh_q <= dr_sh_q;
      endcase
    end else if (tck_rise && tap_state == TAP_SHIFT_DR) begin
      bypass_q <= tdi_m;
    end
  end

  assign live    = port_sel_q & {N_LOCAL{selected_q}};
  assign single  = one_hot(live);
  assign loc_tdi = {sync2_q.tdi_l, pick(sync2_q.tdi, ~m)};

  // selected ports daisy-chain in ascending order into one chain
  always_comb begin
    chain_out = tdi_m;
    loc_tdo_d = {N_LOCAL{IDLE_TDO}};
    for (int p = 0; p < N_LOCAL; p++) begin
      if (live[p]) begin
        loc_tdo_d[p] = chain_out;
        chain_out    = loc_tdi[p];
      end
    end
    if (live == '0) begin
      chain_out = bypass_q;
    end
  end

  // backplane data output, driven only while addressed and shifting
  always_ff @(posedge SYS_CLK_IN or negedge core_rst_n) begin
    if (!core_rst_n) begin
      tdo_q    <= IDLE_TDO;
      tdo_en_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_en_q <= selected_q &&
                  (tap_state == TAP_SHIFT_IR || tap_state == TAP_SHIFT_DR);
      if (tap_state == TAP_SHIFT_IR) begin
        tdo_q <= ir_sh_q[0];
      end else if (ir_q == PORT_SEL_INSTR) begin
        tdo_q <= dr_sh_q[0];
      end else begin
        tdo_q <= chain_out;
      end
    end
  end

  // backplane pins: master side listens, other side acts as local port 0
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      TCK_B_OUT       <= '0;
      TMS_B_OUT       <= '1;
      TRST_B_N_OUT    <= '0;
      TDO_B_OUT       <= '1;
      TCK_B_OE_N_OUT  <= '1;
      TMS_B_OE_N_OUT  <= '1;
      TRST_B_OE_N_OUT <= '1;
      TDO_B_OE_N_OUT  <= '1;
    end else begin
      TCK_B_OUT[~m]       <= tck_m;
      TMS_B_OUT[~m]       <= live[0] ? tms_m : PARK_TMS;
      TRST_B_N_OUT[~m]    <= trst_l0_d;
      TDO_B_OUT[~m]       <= loc_tdo_d[0];
      TCK_B_OE_N_OUT[~m]  <= sync2_q.loc_oe_n;
      TMS_B_OE_N_OUT[~m]  <= sync2_q.loc_oe_n;
      TRST_B_OE_N_OUT[~m] <= sync2_q.loc_oe_n;
      TDO_B_OE_N_OUT[~m]  <= sync2_q.loc_oe_n | ~live[0];
      TCK_B_OUT[m]        <= 1'b0;
      TMS_B_OUT[m]        <= PARK_TMS;
      TRST_B_N_OUT[m]     <= 1'b1;
      TDO_B_OUT[m]        <= tdo_q;
      TCK_B_OE_N_OUT[m]   <= 1'b1;
      TMS_B_OE_N_OUT[m]   <= 1'b1;
      TRST_B_OE_N_OUT[m]  <= 1'b1;
      TDO_B_OE_N_OUT[m]   <= ~tdo_en_q;
    end
  end

  // local ports 1..6
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      TCK_L_OUT      <= '0;
      TMS_L_OUT      <= '1;
      TDO_L_OUT      <= '1;
      TDO_L_OE_N_OUT <= '1;
      LOC_OE_N_OUT   <= 1'b1;
    end else begin
      LOC_OE_N_OUT <= sync2_q.loc_oe_n;
      for (int p = 1; p < N_LOCAL; p++) begin
        TCK_L_OUT[p-1]      <= tck_m;
        TMS_L_OUT[p-1]      <= live[p] ? tms_m : PARK_TMS;
        TDO_L_OUT[p-1]      <= loc_tdo_d[p];
        TDO_L_OE_N_OUT[p-1] <= sync2_q.loc_oe_n | ~live[p];
      end
    end
  end

  // local resets: low under device reset or unmasked backplane reset
  logic trst_ok;
  assign trst_ok = sync2_q.rst_mask | pick(sync2_q.trst_n, m);
  assign trst_l0_d = trst_ok & (live[0] | sync2_q.idle_rst);
  logic [5:0] trst_l_d;
  always_comb begin
    for (int p = 1; p < N_LOCAL; p++) begin
      trst_l_d[p-1] = trst_ok & (live[p] | sync2_q.idle_rst);
    end
  end
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      TRST_L_N_OUT <= '0;
    end else begin
      TRST_L_N_OUT <= trst_l_d;
    end
  end

  // pass-through bits, single selection on ports 0 and 1 only
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      PT_B_OUT      <= '0;
      PT_B_OE_N_OUT <= '1;
      PT_L_OUT      <= '0;
      PT_L_OE_N_OUT <= 1'b1;
    end else begin
      PT_B_OUT[m*PT_W +: PT_W]  <= live[0] ? sync2_q.pt_b[~m] : sync2_q.pt_l;
      PT_B_OE_N_OUT[m]          <= ~(single & (live[0] | live[1]));
      PT_B_OUT[int'(!m)*PT_W +: PT_W] <= sync2_q.pt_b[m];
      PT_B_OE_N_OUT[~m]         <= ~(single & live[0]) | sync2_q.loc_oe_n;
      PT_L_OUT                  <= sync2_q.pt_b[m];
      PT_L_OE_N_OUT             <= ~(single & live[1]) | sync2_q.loc_oe_n;
    end
  end

  // notify mirrors registered data output enables; status mirrors selection registers
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      TRISTATE_NOTIFY_OUT <= '1;
      DEVICE_SELECTED_OUT <= 1'b0;
      PORT_SELECT_OUT     <= PORT_SEL_RESET;
    end else begin
      TRISTATE_NOTIFY_OUT <= {TDO_L_OE_N_OUT[2:0], TDO_B_OE_N_OUT};
      DEVICE_SELECTED_OUT <= selected_q;
      PORT_SELECT_OUT     <= port_sel_q;
    end
  end
endmodule // mdmux_top
`default_nettype wire

//--- verilog/mdmux_pkg.sv
// constants, types and pin bundles shared by the multidrop scan port mux
package mdmux_pkg;
  localparam int N_LOCAL = 7;
  localparam int SLOT_W  = 8;
  localparam int IR_W    = 8;
  localparam int GROUP_W = 2;
  localparam int PT_W    = 2;

  // addressing and instruction codes, all values arbitrary
  localparam logic [IR_W-1:0] BCAST_ADDR      = 8'h3a;
  localparam logic [IR_W-1:0] GROUP_ADDR_BASE = 8'h3c;
  localparam logic [IR_W-1:0] RELEASE_INSTR   = 8'h01;
  localparam logic [IR_W-1:0] PORT_SEL_INSTR  = 8'h02;
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL  = 8'h01;
  localparam logic [IR_W-1:0] IR_RESET_VAL    = 8'h00;
  localparam logic [N_LOCAL-1:0] PORT_SEL_RESET = 7'h00;
  localparam logic PARK_TMS   = 1'b1;
  localparam logic IDLE_TDO   = 1'b1;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;

  // every pin input that crosses into the system clock domain
  typedef struct packed {
    logic [1:0]         tck;
    logic [1:0]         tms;
    logic [1:0]         tdi;
    logic [1:0]         trst_n;
    logic [1:0][PT_W-1:0] pt_b;
    logic [PT_W-1:0]    pt_l;
    logic [N_LOCAL-1:1] tdi_l;
    logic [SLOT_W-1:0]  slot;
    logic [GROUP_W-1:0] group;
    logic               mps;
    logic               loc_oe_n;
    logic               idle_rst;
    logic               rst_mask;
  } pins_t;
endpackage : mdmux_pkg

//--- verilog/tap_fsm.sv
// test access port state sequencer, stepped on each sampled tck rise
`timescale 1ns/10ps
`default_nettype none
module tap_fsm
  import mdmux_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             tck_rise_in,
  input  wire logic             tms_in,
  output var  mdmux_pkg::tap_state_t state_out
);
  tap_state_t state_q;
  tap_state_t state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      TAP_RESET:    state_d = tms_in ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     state_d = tms_in ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   state_d = tms_in ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   state_d = tms_in ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: state_d = tms_in ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: state_d = tms_in ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: state_d = tms_in ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: state_d = tms_in ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   state_d = tms_in ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   state_d = tms_in ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   state_d = tms_in ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: state_d = tms_in ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: state_d = tms_in ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: state_d = tms_in ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: state_d = tms_in ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   state_d = tms_in ? TAP_SEL_DR   : TAP_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= TAP_RESET;
    end else if (tck_rise_in) begin
      state_q <= state_d;
    end
  end

  assign state_out = state_q;
endmodule // tap_fsm
`default_nettype wire

//--- tb/mdmux_checker.sv
// concurrent checks of the scan port mux, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module mdmux_checker
  import mdmux_pkg::*;
(
  input wire logic       SYS_CLK_IN,
  input wire logic       RST_N_IN,
  input wire logic [1:0] TCK_B_IN,
  input wire logic [1:0] TRST_B_N_IN,
  input wire logic [3:0] PT_B_IN,
  input wire logic [1:0] PT_L_IN,
  input wire logic       MASTER_PORT_SELECT_IN,
  input wire logic       LOCAL_OE_N_IN,
  input wire logic       BACKPLANE_RESET_MASK_IN,
  input wire logic [1:0] TDO_B_OE_N_OUT,
  input wire logic [3:0] PT_B_OUT,
  input wire logic [1:0] PT_B_OE_N_OUT,
  input wire logic [4:0] TRISTATE_NOTIFY_OUT,
  input wire logic [5:0] TCK_L_OUT,
  input wire logic [5:0] TRST_L_N_OUT,
  input wire logic [5:0] TDO_L_OE_N_OUT,
  input wire logic       LOC_OE_N_OUT,
  input wire logic [1:0] PT_L_OUT,
  input wire logic       PT_L_OE_N_OUT,
  input wire logic       DEVICE_SELECTED_OUT,
  input wire logic [6:0] PORT_SELECT_OUT
);
  logic       mps;
  logic [1:0] m_pt;
  logic [1:0] m_pt_out;
  assign mps = MASTER_PORT_SELECT_IN;
  assign m_pt = mps ? PT_B_IN[3:2] : PT_B_IN[1:0];
  assign m_pt_out = mps ? PT_B_OUT[3:2] : PT_B_OUT[1:0];
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // notify trails the enable registers by one cycle
  a_notify_backplane: assert property (TRISTATE_NOTIFY_OUT[1:0] == $past(TDO_B_OE_N_OUT))
    else $error("backplane notify disagrees with data enable");
  a_notify_local: assert property (TRISTATE_NOTIFY_OUT[4:2] == $past(TDO_L_OE_N_OUT[2:0]))
    else $error("local notify disagrees with data enable");
  a_local_float: assert property (LOCAL_OE_N_IN [*5] |-> LOC_OE_N_OUT && TDO_L_OE_N_OUT == 6'h3f)
    else $error("local port driven while disabled");
  a_master_quiet: assert property (!DEVICE_SELECTED_OUT && !$past(DEVICE_SELECTED_OUT)
    |-> TDO_B_OE_N_OUT[mps])
    else $error("unaddressed device drives backplane data");
  a_pt_off: assert property (!(PORT_SELECT_OUT inside {7'h01, 7'h02}) [*3]
    |-> PT_L_OE_N_OUT && PT_B_OE_N_OUT == 2'b11)
    else $error("pass-through driven without single port");
  a_pt_forward: assert property ((DEVICE_SELECTED_OUT && PORT_SELECT_OUT == 7'h02 &&
    !LOCAL_OE_N_IN) [*4]
    |-> !PT_L_OE_N_OUT && PT_L_OUT == $past(m_pt, 3))
    else $error("local pass-through out wrong");
  a_pt_return: assert property ((DEVICE_SELECTED_OUT && PORT_SELECT_OUT == 7'h02) [*4]
    |-> !PT_B_OE_N_OUT[mps] && m_pt_out == $past(PT_L_IN, 3))
    else $error("backplane pass-through out wrong");
  a_tck_copy: assert property (!LOC_OE_N_OUT |-> TCK_L_OUT == {6{$past(TCK_B_IN[mps], 3)}})
    else $error("local clock is not the master clock");
  a_trst_gate: assert property ((!TRST_B_N_IN[mps] && !BACKPLANE_RESET_MASK_IN) [*4]
    |-> TRST_L_N_OUT == 6'h00)
    else $error("local reset not gated low");
  a_trst_init: assert property ((!TRST_B_N_IN[mps]) [*2]
    |-> !DEVICE_SELECTED_OUT && PORT_SELECT_OUT == 7'h00)
    else $error("test reset left selection set");
endmodule // mdmux_checker

bind mdmux_top mdmux_checker chk (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN), .TCK_B_IN(TCK_B_IN),
  .TRST_B_N_IN(TRST_B_N_IN), .PT_B_IN(PT_B_IN), .PT_L_IN(PT_L_IN),
  .MASTER_PORT_SELECT_IN(MASTER_PORT_SELECT_IN), .LOCAL_OE_N_IN(LOCAL_OE_N_IN),
  .BACKPLANE_RESET_MASK_IN(BACKPLANE_RESET_MASK_IN), .TDO_B_OE_N_OUT(TDO_B_OE_N_OUT),
  .PT_B_OUT(PT_B_OUT), .PT_B_OE_N_OUT(PT_B_OE_N_OUT), .TCK_L_OUT(TCK_L_OUT),
  .TRISTATE_NOTIFY_OUT(TRISTATE_NOTIFY_OUT), .TRST_L_N_OUT(TRST_L_N_OUT),
  .TDO_L_OE_N_OUT(TDO_L_OE_N_OUT), .LOC_OE_N_OUT(LOC_OE_N_OUT), .PT_L_OUT(PT_L_OUT),
  .PT_L_OE_N_OUT(PT_L_OE_N_OUT), .DEVICE_SELECTED_OUT(DEVICE_SELECTED_OUT),
  .PORT_SELECT_OUT(PORT_SELECT_OUT));
`default_nettype wire

//--- tb/scan_master_model.sv
// scan master on the backplane port, one tck period per bit_step call
`timescale 1ns/10ps
`default_nettype none
module scan_master_model
  import mdmux_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic tdo_in,
  output var  logic tck_out,
  output var  logic tms_out,
  output var  logic tdi_out,
  output var  logic trst_n_out
);
  logic [IR_W-1:0] cap_q;
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
    trst_n_out = 1'b1;
    cap_q = '0;
  end
  // tck stands low between calls; master alone makes it
  task automatic bit_step(input logic tms, input logic tdi, input int idx);
    @(posedge clk_in);
    tms_out <= tms;
    tdi_out <= tdi;
    repeat (3) @(posedge clk_in);
    tck_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    // sampled late in the high phase: data output lags tck by several cycles
    if (idx >= 0 && idx < IR_W) cap_q[idx] = tdo_in;
    tck_out <= 1'b0;
  endtask
  // from idle through one scan back to idle, lsb first
  task automatic scan(input logic ir, input logic [7:0] val, input int n);
    bit_step(1'b1, 1'b1, -1);
    if (ir) bit_step(1'b1, 1'b1, -1);
    bit_step(1'b0, 1'b1, -1);
    bit_step(1'b0, 1'b1, -1);
    for (int i = 0; i < n; i++) bit_step(i == n - 1, val[i], i);
    bit_step(1'b1, 1'b1, -1);
    bit_step(1'b0, 1'b1, -1);
    // update lands three cycles after the rise, status one more
    repeat (2) @(posedge clk_in);
  endtask
  task automatic to_idle();
    repeat (5) bit_step(1'b1, 1'b1, -1);
    bit_step(1'b0, 1'b1, -1);
  endtask
  task automatic set_trst(input logic v);
    @(posedge clk_in);
    trst_n_out <= v;
  endtask
endmodule // scan_master_model
`default_nettype wire

//--- tb/tb_top.sv
// testbench for the multidrop scan port mux
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import mdmux_pkg::*;
  localparam logic [7:0] SLOT = 8'h5c;
  logic       clk, rst_n, mps, loc_oe_n, idle_lvl, mask, m_tck, m_tms, m_tdi, m_trst_n, m_tdo;
  logic       loc_oe_o, pt_l_oe_n, dev_sel, tgl_q = 1'b0;
  logic [1:0] tck_b, tms_b, trst_b, tdi_b, pt_l_in, pt_l_o, grp, pt_b_oe_n;
  logic [1:0] tck_o, tck_oe, tms_o, tms_oe, trst_o, trst_oe, tdo_o, tdo_oe;
  logic [3:0] pt_b_in, pt_b_o;
  logic [4:0] notify;
  logic [5:0] tck_l, tms_l, trst_l, tdo_l, tdo_l_oe, tdi_l;
  logic [6:0] port_sel;
  int         err_total, n_checks;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // released lines: pull-ups read high, tck and tdo show a changing pattern
  always @(posedge clk) tgl_q <= ~tgl_q;
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      tck_b[p] = (p == int'(mps)) ? m_tck : (tck_oe[p] ? tgl_q : tck_o[p]);
      tms_b[p] = (p == int'(mps)) ? m_tms : (tms_oe[p] ? 1'b1 : tms_o[p]);
      trst_b[p] = (p == int'(mps)) ? m_trst_n : (trst_oe[p] ? 1'b1 : trst_o[p]);
      tdi_b[p] = (p == int'(mps)) ? m_tdi : 1'b1;
    end
  end
  assign m_tdo = tdo_oe[mps] ? tgl_q : tdo_o[mps];

  scan_master_model m (.clk_in(clk), .tdo_in(m_tdo), .tck_out(m_tck), .tms_out(m_tms),
    .tdi_out(m_tdi), .trst_n_out(m_trst_n));

  mdmux_top DUT (.TCK_B_IN(tck_b), .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .TCK_B_OUT(tck_o),
    .TCK_B_OE_N_OUT(tck_oe), .TMS_B_IN(tms_b), .TMS_B_OUT(tms_o), .TMS_B_OE_N_OUT(tms_oe),
    .TRST_B_N_IN(trst_b), .TRST_B_N_OUT(trst_o), .TRST_B_OE_N_OUT(trst_oe),
    .TDI_B_IN(tdi_b), .TDO_B_OUT(tdo_o), .TDO_B_OE_N_OUT(tdo_oe), .PT_B_IN(pt_b_in),
    .PT_B_OUT(pt_b_o), .PT_B_OE_N_OUT(pt_b_oe_n), .TRISTATE_NOTIFY_OUT(notify),
    .TCK_L_OUT(tck_l), .TMS_L_OUT(tms_l), .TRST_L_N_OUT(trst_l), .TDO_L_OUT(tdo_l),
    .TDO_L_OE_N_OUT(tdo_l_oe), .LOC_OE_N_OUT(loc_oe_o), .TDI_L_IN(tdi_l),
    .PT_L_IN(pt_l_in), .PT_L_OUT(pt_l_o), .PT_L_OE_N_OUT(pt_l_oe_n), .SLOT_ID_IN(SLOT),
    .GROUP_ID_IN(grp), .MASTER_PORT_SELECT_IN(mps), .LOCAL_OE_N_IN(loc_oe_n),
    .IDLE_LOCAL_RESET_LEVEL_IN(idle_lvl), .BACKPLANE_RESET_MASK_IN(mask),
    .DEVICE_SELECTED_OUT(dev_sel), .PORT_SELECT_OUT(port_sel));

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    mps = 1'b0;
    loc_oe_n = 1'b0;
    idle_lvl = 1'b1;
    mask = 1'b0;
    grp = 2'h1;
    pt_b_in = 4'h0;
    pt_l_in = 2'h0;
    tdi_l = 6'h15;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    check(notify, 8'h1f, "notify after reset");
    check(tdo_oe, 8'h03, "backplane data floats");
    check(tck_oe, 8'h01, "slave port drives clock");
    m.to_idle();
    m.scan(1'b1, 8'h77, IR_W);
    check(dev_sel, 8'h00, "foreign address selects");
    // own slot, broadcast and group, each then released
    for (int k = 0; k < 3; k++) begin
      m.scan(1'b1, (k == 0) ? SLOT : (k == 1) ? BCAST_ADDR : GROUP_ADDR_BASE + 8'(grp), IR_W);
      check(dev_sel, 8'h01, "address not taken");
      m.scan(1'b1, RELEASE_INSTR, IR_W);
      check(m.cap_q, IR_CAPTURE_VAL, "capture on data out");
      check(dev_sel, 8'h00, "release ignored");
    end
    m.scan(1'b1, SLOT, IR_W);
    m.scan(1'b1, PORT_SEL_INSTR, IR_W);
    m.scan(1'b0, 8'h02, N_LOCAL);
    check(port_sel, 8'h02, "port select");
    check(tms_l, 8'h3e, "live port follows mode select");
    pt_b_in <= 4'h2;
    pt_l_in <= 2'h1;
    settle();
    check(pt_l_o, 8'h02, "pass-through to local");
    check(pt_b_o[1:0], 8'h01, "pass-through to backplane");
    check(tdo_l_oe, 8'h3e, "live port data enable");
    idle_lvl <= 1'b0;
    settle();
    check(trst_l, 8'h01, "idle reset level");
    loc_oe_n <= 1'b1;
    settle();
    check({loc_oe_o, tdo_l_oe}, 8'h7f, "local ports float");
    loc_oe_n <= 1'b0;
    m.scan(1'b0, 8'h06, N_LOCAL);
    settle();
    check({pt_l_oe_n, pt_b_oe_n}, 8'h07, "pass-through with two ports");
    idle_lvl <= 1'b1;
    // backplane test reset, then the same with the mask set
    for (int k = 0; k < 2; k++) begin
      mask <= k[0];
      m.set_trst(1'b0);
      settle();
      check(trst_l, k[0] ? 8'h3f : 8'h00, "local reset gate");
      check(trst_o[1], k[0] ? 8'h01 : 8'h00, "slave port reset gate");
      check({dev_sel, port_sel}, 8'h00, "test reset clears selection");
      m.set_trst(1'b1);
    end
    rst_n <= 1'b0;
    mps <= 1'b1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    check(tck_oe, 8'h02, "port one is master");
    m.to_idle();
    m.scan(1'b1, SLOT, IR_W);
    check(dev_sel, 8'h01, "address through port one");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
